// file: bench/lsdma_engine_tb_top.sv
// Purpose: Self-checking bench for the read DMA engine.
// Assumes: Far-side model answers requests; status answers are always accepted.
// Notes:   Expected memory contents are computed from host addresses.
`timescale 1ns/1ns
module lsdma_engine_tb_top;
    import lsdma_pkg::*;
    logic        sys_clk = 0, arst_n = 0, clk_en = 1, post_valid = 0, npr_valid = 0;
    logic        txr_ready = 1, slow = 0;
    logic [1:0]  post_reg = '0;
    logic [31:0] post_data = '0, inflight = '0;
    logic [4:0]  npr_tag = '0;
    logic [5:0]  hold_n = 6'h03;
    logic        post_ready, npr_ready, txr_valid, req_valid, req_ready, rsp_valid;
    logic        rsp_ready, rsp_is_cmd, sd_cmd_valid, sd_cmd_ready, sd_data_valid;
    logic        sd_data_ready, sd_written, busy;
    logic [4:0]  txr_tag, req_tag, rsp_tag;
    logic [31:0] txr_data, req_addr, rsp_data, sd_cmd_addr, sd_data;
    logic [3:0]  req_words, sd_cmd_words;
    int          n_mismatch = 0, n_tests = 0, outst = 0, max_out = 0, words_req = 0;
    int          n_bnd = 0, n_dup = 0, n_refuse = 0, n_wr = 0, nw;
    always #4 sys_clk = ~sys_clk;
    lsdma_engine #(.TAG_BITS(5), .FIFO_DEPTH(16)) dut_u (.sys_clk(sys_clk),
        .arst_n(arst_n), .clk_en(clk_en), .post_valid(post_valid), .post_ready(post_ready),
        .post_reg(post_reg), .post_data(post_data), .npr_valid(npr_valid),
        .npr_ready(npr_ready), .npr_tag(npr_tag), .txr_valid(txr_valid), .txr_ready(txr_ready),
        .txr_tag(txr_tag), .txr_data(txr_data), .req_valid(req_valid), .req_ready(req_ready),
        .req_addr(req_addr), .req_words(req_words), .req_tag(req_tag), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_is_cmd(rsp_is_cmd), .rsp_tag(rsp_tag), .rsp_data(rsp_data),
        .sd_cmd_valid(sd_cmd_valid), .sd_cmd_ready(sd_cmd_ready), .sd_cmd_addr(sd_cmd_addr),
        .sd_cmd_words(sd_cmd_words), .sd_data_valid(sd_data_valid),
        .sd_data_ready(sd_data_ready), .sd_data(sd_data), .sd_written(sd_written), .busy(busy));
    lsdma_far_model #(.TAG_BITS(5)) mdl_u (.sys_clk(sys_clk), .slow(slow), .hold_n(hold_n),
        .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
        .req_words(req_words), .req_tag(req_tag), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_is_cmd(rsp_is_cmd), .rsp_tag(rsp_tag), .rsp_data(rsp_data),
        .sd_cmd_valid(sd_cmd_valid), .sd_cmd_ready(sd_cmd_ready), .sd_cmd_addr(sd_cmd_addr),
        .sd_cmd_words(sd_cmd_words), .sd_data_valid(sd_data_valid),
        .sd_data_ready(sd_data_ready), .sd_data(sd_data), .sd_written(sd_written));
    // ------------------------------------------------------------------
    // Traffic monitor
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (req_valid && req_ready && clk_en) begin
            nw = (req_words == 4'h0) ? 16 : int'(req_words);
            if (int'(req_addr[5:0]) + nw * 4 > 64) n_bnd++;
            if (inflight[req_tag]) n_dup++;
            inflight[req_tag] = 1'b1;
            outst++;
            words_req += nw;
            if (outst > max_out) max_out = outst;
        end
        if (rsp_valid && rsp_ready && rsp_is_cmd) begin
            inflight[rsp_tag] = 1'b0;
            outst--;
        end
        if (rsp_valid && !rsp_ready && !rsp_is_cmd) n_refuse++;
        if (sd_written === 1'b1) n_wr++;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [1:0] r, logic [31:0] d);
        @(posedge sys_clk);
        #1 {post_valid, post_reg, post_data} = {1'b1, r, d};
        @(posedge sys_clk);
        #1 post_valid = 1'b0;
    endtask
    task automatic status(logic [31:0] exp);
        int k;
        @(posedge sys_clk);
        #1 {npr_valid, npr_tag} = {1'b1, 5'h0B};
        k = 0;
        do begin @(posedge sys_clk); k++; end while (npr_ready !== 1'b1 && k < 50);
        #1 npr_valid = 1'b0;
        while (txr_valid !== 1'b1 && k < 100) begin @(posedge sys_clk); #1 k++; end
        chk("status answered", 32'h1, {31'h0, k < 100});
        chk("status tag", 32'h0B, {27'h0, txr_tag});
        chk("status value", exp, txr_data);
        @(posedge sys_clk);
    endtask
    task automatic run(string name, logic [31:0] host, sd, len, logic s, logic [5:0] h,
                       logic restart, int maxo);
        int k;
        @(posedge sys_clk);
        #1 {slow, hold_n} = {s, h};
        {max_out, words_req, n_bnd, n_dup, n_refuse, n_wr} = '0;
        wr(REG_HOST_ADDR, host);
        wr(REG_SDRAM_ADDR, sd);
        wr(REG_LENGTH, len);
        wr(REG_START, 32'h0);
        @(posedge sys_clk);
        #1 chk("busy after start", 32'h1, {31'h0, busy});
        status(STATUS_BUSY);
        if (restart) wr(REG_START, 32'h0);
        k = 0;
        while (busy !== 1'b0 && k < 20000) begin @(posedge sys_clk); k++; end
        if (k == 20000) begin
            chk("transfer finished", 32'h1, 32'h0);
            test_done();
        end
        chk("words requested", len, 32'(words_req));
        chk("words written", len, 32'(n_wr));
        chk("boundary crossings", 32'h0, 32'(n_bnd));
        chk("duplicate tags", 32'h0, 32'(n_dup));
        chk("overlapped requests", 32'h1, {31'h0, max_out >= 2});
        if (maxo != 0) chk("tag limit", 32'(maxo), 32'(max_out));
        if (s) chk("response stalled", 32'h1, {31'h0, n_refuse > 0});
        for (int i = 0; i < int'(len); i++)
            chk("sdram word", (host + 32'(4 * i)) ^ 32'h5A5A_0000,
                mdl_u.mem[sd[11:2] + 10'(i)]);
        status(STATUS_DONE);
        $display("test %s finished", name);
    endtask
    task automatic test_reset();
        chk("idle outputs", 32'h0, {27'h0, busy, req_valid, sd_cmd_valid, sd_data_valid,
            txr_valid});
        $display("test reset finished");
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        test_reset();
        run("unaligned", 32'h0000_003C, 32'h0000_0100, 32'd4, 1'b0, 6'h03, 1'b0, 0);
        run("restart", 32'h0000_1004, 32'h0000_0200, 32'd100, 1'b0, 6'h03, 1'b1, 0);
        run("stall", 32'h0000_2020, 32'h0000_0040, 32'd40, 1'b1, 6'h02, 1'b0, 0);
        run("tags", 32'h0000_4000, 32'h0000_0000, 32'd640, 1'b0, 6'h20, 1'b0, 32);
        test_done();
    end
endmodule

// file: bench/lsdma_far_model.sv
// Purpose: Far-side model: link core buffers and SDRAM controller.
// Assumes: A word count of zero means sixteen words.
// Notes:   Responses go newest first, so the tag lookup is really exercised.
`timescale 1ns/1ns
module lsdma_far_model #(
    parameter int TAG_BITS = 5
) (
    // Clock and mode
    input  wire logic                sys_clk,
    input  wire logic                slow,
    input  wire logic [5:0]          hold_n,
    // Read requests
    input  wire logic                req_valid,
    output logic                     req_ready,
    input  wire logic [31:0]         req_addr,
    input  wire logic [3:0]          req_words,
    input  wire logic [TAG_BITS-1:0] req_tag,
    // Responses
    output logic                     rsp_valid,
    input  wire logic                rsp_ready,
    output logic                     rsp_is_cmd,
    output logic [TAG_BITS-1:0]      rsp_tag,
    output logic [31:0]              rsp_data,
    // SDRAM controller
    input  wire logic                sd_cmd_valid,
    output logic                     sd_cmd_ready,
    input  wire logic [31:0]         sd_cmd_addr,
    input  wire logic [3:0]          sd_cmd_words,
    input  wire logic                sd_data_valid,
    output logic                     sd_data_ready,
    input  wire logic [31:0]         sd_data,
    output logic                     sd_written
);
    logic [31:0]         mem [0:1023];
    logic [31:0]         q_addr [$];
    logic [TAG_BITS-1:0] q_tag [$];
    int                  q_len [$];
    logic [9:0]          s_ptr [$];
    int                  s_left [$];
    logic [31:0]         cur_a;
    logic [TAG_BITS-1:0] cur_t;
    int                  n, bi, idle, cyc;
    logic                act, gap, wr;
    initial begin
        {req_ready, rsp_valid, rsp_is_cmd, sd_cmd_ready, sd_data_ready, sd_written} = '0;
        rsp_tag = '0;
        rsp_data = '0;
        {act, gap, wr, cur_a, cur_t} = '0;
        {n, bi, idle, cyc} = '0;
    end
    always @(posedge sys_clk) begin
        if (sd_cmd_valid && sd_cmd_ready) begin
            s_ptr.push_back(sd_cmd_addr[11:2]);
            s_left.push_back(sd_cmd_words == 4'h0 ? 16 : int'(sd_cmd_words));
        end
        wr = sd_data_valid && sd_data_ready && s_ptr.size() > 0;
        if (wr) begin
            mem[s_ptr[0]] = sd_data;
            s_ptr[0] = s_ptr[0] + 10'h001;
            s_left[0]--;
            if (s_left[0] == 0) begin
                void'(s_ptr.pop_front());
                void'(s_left.pop_front());
            end
        end
        if (req_valid && req_ready) begin
            q_addr.push_back(req_addr);
            q_tag.push_back(req_tag);
            q_len.push_back(req_words == 4'h0 ? 16 : int'(req_words));
            idle = 0;
        end else begin
            idle++;
        end
        gap = 1'b0;
        if (rsp_valid && rsp_ready) begin
            bi++;
            gap = slow;
            if (bi > n) act = 1'b0;
        end
        if (!act && q_addr.size() > 0 && (q_addr.size() >= hold_n || idle >= 4)) begin
            cur_a = q_addr.pop_back();
            cur_t = q_tag.pop_back();
            n = q_len.pop_back();
            act = 1'b1;
            bi = 0;
        end
        cyc++;
        #1;
        req_ready = !slow || cyc[0];
        rsp_valid = act && !gap;
        rsp_is_cmd = act && bi == 0;
        rsp_tag = cur_t;
        rsp_data = !rsp_valid ? ~rsp_data : (bi == 0) ? ~cur_a :
                   (cur_a + 32'(4 * (bi - 1))) ^ 32'h5A5A_0000;
        sd_cmd_ready = !slow || cyc[1];
        // Long stalls here let the response FIFO fill until it refuses.
        // Data is only taken once a command has said where it goes.
        sd_data_ready = (!slow || cyc[5:3] == 3'h0) && s_ptr.size() > 0;
        sd_written = wr;
    end
endmodule

// file: hw/lsdma_engine.sv
// Purpose: Read DMA that fetches host memory over the link and writes it to SDRAM.
// Assumes: Link buffers present word-wide valid/ready streams from the core clock domain.
// Notes:   Response data passes through a 16-word FIFO before the SDRAM controller.
`timescale 1ns/1ns
module lsdma_engine
    import lsdma_pkg::*;
#(
    parameter int TAG_BITS = 5,
    parameter int FIFO_DEPTH = 16
) (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    // Receive posted path: control register writes
    input  wire logic        post_valid,
    output logic             post_ready,
    input  wire logic [1:0]  post_reg,
    input  wire logic [31:0] post_data,
    // Receive non-posted path: status reads
    input  wire logic        npr_valid,
    output logic             npr_ready,
    input  wire logic [TAG_BITS-1:0] npr_tag,
    // Transmit response buffer: status answers
    output logic             txr_valid,
    input  wire logic        txr_ready,
    output logic [TAG_BITS-1:0] txr_tag,
    output logic [31:0]      txr_data,
    // Transmit non-posted buffer: read requests
    output logic             req_valid,
    input  wire logic        req_ready,
    output logic [31:0]      req_addr,
    output logic [3:0]       req_words,
    output logic [TAG_BITS-1:0] req_tag,
    // Receive response buffer: command then data words
    input  wire logic        rsp_valid,
    output logic             rsp_ready,
    input  wire logic        rsp_is_cmd,
    input  wire logic [TAG_BITS-1:0] rsp_tag,
    input  wire logic [31:0] rsp_data,
    // SDRAM controller
    output logic             sd_cmd_valid,
    input  wire logic        sd_cmd_ready,
    output logic [31:0]      sd_cmd_addr,
    output logic [3:0]       sd_cmd_words,
    output logic             sd_data_valid,
    input  wire logic        sd_data_ready,
    output logic [31:0]      sd_data,
    input  wire logic        sd_written,
    // Status
    output logic             busy
);
    localparam int NTAG = 1 << TAG_BITS;
    localparam int BWORDS = BOUNDARY_BYTES / WORD_BYTES;
    initial begin
        if (TAG_BITS < 1 || TAG_BITS > 5) $error("lsdma_engine: TAG_BITS must be 1..5");
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    lsdma_state_t state;
    logic [31:0]  host_addr;
    logic [31:0]  sd_base;
    logic [31:0]  len_words;
    logic [31:0]  left_req;
    logic [31:0]  left_wr;
    logic [31:0]  req_host;
    logic [31:0]  req_sd;

    assign post_ready = 1'b1;
    wire post_take = post_valid && clk_en;
    wire start_cmd = post_take && post_reg == REG_START && state != ST_RUN;

    // ----------------------------------------------------------------
    // Tag table
    // ----------------------------------------------------------------
    logic [NTAG-1:0] tag_busy;
    logic [31:0]     tag_addr [NTAG];
    logic [3:0]      tag_len  [NTAG];
    logic [TAG_BITS-1:0] free_tag;
    logic                any_free;
    always_comb begin
        free_tag = '0;
        any_free = 1'b0;
        for (int i = NTAG - 1; i >= 0; i--) begin
            if (!tag_busy[i]) begin
                free_tag = TAG_BITS'(i);
                any_free = 1'b1;
            end
        end
    end

    // Split at the aligned boundary: words left to the boundary, capped by remaining.
    wire [31:0] to_bnd = 32'(BWORDS) - {28'h0, req_host[5:2]};
    wire [31:0] chunk  = (left_req < to_bnd) ? left_req : to_bnd;
    wire        can_issue = state == ST_RUN && left_req != '0 && any_free
                            && (!req_valid || req_ready);

    // ----------------------------------------------------------------
    // Response handling
    // ----------------------------------------------------------------
    logic                in_pkt;
    logic [TAG_BITS-1:0] cur_tag;
    logic [3:0]          cur_left;
    logic                f_in_ready;
    wire cmd_slot = !sd_cmd_valid || sd_cmd_ready;
    assign rsp_ready = clk_en && (rsp_is_cmd ? (!in_pkt && cmd_slot) : (in_pkt && f_in_ready));
    wire rsp_cmd_take  = rsp_valid && rsp_ready && rsp_is_cmd;
    wire rsp_data_take = rsp_valid && rsp_ready && !rsp_is_cmd;
    wire last_word     = rsp_data_take && cur_left == 4'h1;
    wire f_out_valid;
    wire [31:0] f_out_data;
    wire drain = !sd_data_valid || sd_data_ready;

    lsdma_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .in_valid  (rsp_data_take),
        .in_ready  (f_in_ready),
        .in_data   (rsp_data),
        .out_valid (f_out_valid),
        .out_ready (drain),
        .out_data  (f_out_data)
    );

    wire all_done = left_req == '0 && tag_busy == '0 && left_wr == '0;

    // ----------------------------------------------------------------
    // Sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            host_addr <= '0;
            sd_base <= '0;
            len_words <= '0;
            left_req <= '0;
            left_wr <= '0;
            req_host <= '0;
            req_sd <= '0;
            req_valid <= 1'b0;
            req_addr <= '0;
            req_words <= '0;
            req_tag <= '0;
            tag_busy <= '0;
            in_pkt <= 1'b0;
            cur_tag <= '0;
            cur_left <= '0;
            sd_cmd_valid <= 1'b0;
            sd_cmd_addr <= '0;
            sd_cmd_words <= '0;
            sd_data_valid <= 1'b0;
            sd_data <= '0;
            busy <= 1'b0;
        end else if (clk_en) begin
            if (post_take && post_reg == REG_HOST_ADDR) host_addr <= post_data;
            if (post_take && post_reg == REG_SDRAM_ADDR) sd_base <= post_data;
            if (post_take && post_reg == REG_LENGTH) len_words <= post_data;
            if (start_cmd) begin
                state <= ST_RUN;
                left_req <= len_words;
                left_wr <= len_words;
                req_host <= {host_addr[31:2], 2'b00};
                req_sd <= sd_base;
            end else if (state == ST_RUN && all_done) begin
                state <= ST_DONE;
            end
            busy <= start_cmd || (state == ST_RUN && !all_done);
            if (req_valid && req_ready) req_valid <= 1'b0;
            if (can_issue) begin
                req_valid <= 1'b1;
                req_addr <= req_host;
                req_words <= chunk[3:0];
                req_tag <= free_tag;
                tag_addr[free_tag] <= req_sd;
                tag_len[free_tag] <= chunk[3:0];
                req_host <= req_host + (chunk << 2);
                req_sd <= req_sd + (chunk << 2);
                left_req <= left_req - chunk;
            end
            if (sd_cmd_valid && sd_cmd_ready) sd_cmd_valid <= 1'b0;
            if (rsp_cmd_take) begin
                in_pkt <= 1'b1;
                cur_tag <= rsp_tag;
                cur_left <= tag_len[rsp_tag];
                sd_cmd_valid <= 1'b1;
                sd_cmd_addr <= tag_addr[rsp_tag];
                sd_cmd_words <= tag_len[rsp_tag];
            end
            if (rsp_data_take) cur_left <= cur_left - 4'h1;
            if (last_word) in_pkt <= 1'b0;
            for (int i = 0; i < NTAG; i++) begin
                if (can_issue && free_tag == TAG_BITS'(i)) tag_busy[i] <= 1'b1;
                else if (last_word && cur_tag == TAG_BITS'(i)) tag_busy[i] <= 1'b0;
            end
            if (drain) begin
                sd_data_valid <= f_out_valid;
                sd_data <= f_out_data;
            end
            if (sd_written && left_wr != '0) left_wr <= left_wr - 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // Status reads
    // ----------------------------------------------------------------
    assign npr_ready = clk_en && (!txr_valid || txr_ready);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            txr_valid <= 1'b0;
            txr_tag <= '0;
            txr_data <= '0;
        end else if (clk_en) begin
            if (txr_valid && txr_ready) txr_valid <= 1'b0;
            if (npr_valid && npr_ready) begin
                txr_valid <= 1'b1;
                txr_tag <= npr_tag;
                txr_data <= (state == ST_DONE) ? STATUS_DONE : STATUS_BUSY;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_issue;
        can_issue && clk_en;
    endsequence
    issue_free_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_issue |-> !tag_busy[free_tag]) else $error("Request issued on a busy tag");
    tag_marked_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_issue |=> tag_busy[req_tag] && req_valid) else $error("Issued tag not held");
    no_cross_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req_valid |-> ({28'h0, req_addr[5:2]}
        + ((req_words == 4'h0) ? 32'(BWORDS) : {28'h0, req_words})) <= 32'(BWORDS))
        else $error("Request crosses boundary");
    req_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req_valid && !req_ready && clk_en |=> req_valid && $stable(req_addr))
        else $error("Request dropped before accepted");
    cmd_follow_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rsp_cmd_take |=> sd_cmd_valid && sd_cmd_addr == $past(tag_addr[rsp_tag]))
        else $error("SDRAM command missing after response");
    reg_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        post_take && post_reg == REG_LENGTH |=> len_words == $past(post_data))
        else $error("Length register not loaded");
    status_ans_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        npr_valid && npr_ready |=> txr_valid && txr_data == (($past(state) == ST_DONE)
        ? STATUS_DONE : STATUS_BUSY)) else $error("Status answer wrong");
    done_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state == ST_DONE |-> tag_busy == '0 && left_req == '0) else $error("Done too early");
endmodule

// file: hw/lsdma_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides.
// Assumes: Depth is a power of two.
// Notes:   Full and empty come from a count, so no slot is wasted.
`timescale 1ns/1ns
module lsdma_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic             clk_en,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("lsdma_fifo: DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (clk_en) begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && push) mem[wr_ptr] <= in_data;
    end

    fifo_bound_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        count <= (AW+1)'(DEPTH)) else $error("FIFO count exceeds depth");
endmodule

// file: hw/lsdma_pkg.sv
// Purpose: Constants shared by the link-to-SDRAM read DMA engine.
// Assumes: 32-bit data words on the link buffers, byte addressing.
// Notes:   The posted-write and status packet layout is a local simplification.
//
// Functional notes
// - Host posted writes arriving on the receive posted path load control registers.
// - Read requests are written into the transmit non-posted buffer.
// - Requests are issued back to back, many outstanding at once.
// - Engine assigns each in-flight request a unique source tag in the packet.
// - No read request crosses an aligned 64-byte boundary.
// - Response command is popped; its tag looks up the SDRAM address.
// - Each response sends the looked-up address with a write command to SDRAM.
// - Response data is read and forwarded; SDRAM controller writes it.
// - Engine runs until all requested, all returned, all written.
// - Host status read gets a read response showing completion.
package lsdma_pkg;
    // Control register indices carried in posted writes.
    localparam logic [1:0]  REG_HOST_ADDR  = 2'h0;
    localparam logic [1:0]  REG_SDRAM_ADDR = 2'h1;
    localparam logic [1:0]  REG_LENGTH     = 2'h2;
    localparam logic [1:0]  REG_START      = 2'h3;
    // Request sizing and status values.
    localparam int          BOUNDARY_BYTES = 64;
    localparam int          WORD_BYTES     = 4;
    localparam logic [31:0] STATUS_DONE    = 32'h0000_0001;
    localparam logic [31:0] STATUS_BUSY    = 32'h0000_0000;
    // Engine state.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b10
    } lsdma_state_t;
endpackage
